// *** bmu_mult.sv ***
// combinational 8x8 unsigned multiplier
`timescale 1ns/10ps
module bmu_mult #(
   parameter int WIDTH = 8
) (
   // operands
   input wire logic [WIDTH-1:0] i_a,
   input wire logic [WIDTH-1:0] i_b,
   // product
   output logic [2*WIDTH-1:0] o_p
);
   // a width below one leaves no product to form
   if (WIDTH < 1) begin : g_bad_width
      $error("bmu_mult width must be positive");
   end
   // zero-extend both so the product stays unsigned
   always_comb begin
      o_p = {{WIDTH{1'b0}}, i_a} * {{WIDTH{1'b0}}, i_b};
   end
endmodule : bmu_mult

// *** bmu_params.svh ***
// constants for the byte multiply unit
`ifndef BMU_PARAMS_SVH
`define BMU_PARAMS_SVH
`define BMU_OPC_IMM_HI 8'h0d
`define BMU_OPC_FILE_HI 7'h01
`define BMU_PROD_RST 8'h00
`define BMU_ACC_HIGH_BASE 8'h80
`define BMU_ACC_HIGH_BANK 4'hf
`endif

// *** bmu_pkg.sv ***
// types for the byte multiply unit
package bmu_pkg;
   typedef enum logic [1:0] {
      BMU_OP_NONE,
      BMU_OP_IMM,
      BMU_OP_FILE
   } bmu_op_e;
   typedef logic [11:0] bmu_addr_t;
endpackage : bmu_pkg

// *** bmu_top.sv ***
// byte multiply unit: decode, operand address, product register pair
// Behaviour
// - immediate multiply uses accumulator times 8-bit literal, both unsigned
// - immediate multiply writes 16-bit product, high byte to high register
// - immediate multiply never changes the accumulator
// - no multiply changes any status flag, zero product undetected
// - file multiply forms unsigned accumulator times memory byte product
// - file multiply leaves accumulator and memory byte unchanged
// - file multiply recognised by top seven bits 0000001, bit 8 bank mode
// - bank mode clear selects access bank, bank register ignored
// - bank mode set uses bank held in bank select register
`include "bmu_params.svh"
`timescale 1ns/10ps
module bmu_top
   import bmu_pkg::*;
#(
   parameter int DATA_W = 8
) (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_reset_n,
   // instruction from decoder, valid for one instruction cycle
   input wire logic i_instr_valid,
   input wire logic [15:0] i_instr,
   // core state
   input wire logic [DATA_W-1:0] i_acc,
   input wire logic [3:0] i_bank_select_register,
   input wire logic [DATA_W-1:0] i_status,
   // data memory read
   output logic [11:0] o_mem_addr,
   input wire logic [DATA_W-1:0] i_mem_rdata,
   // results
   output logic [DATA_W-1:0] o_product_high_byte,
   output logic [DATA_W-1:0] o_product_low_byte,
   output logic o_prod_wr,
   output logic [DATA_W-1:0] o_acc,
   output logic [DATA_W-1:0] o_status
);
   // literal field and memory byte are fixed at eight bits
   if (DATA_W != 8) begin : g_bad_width
      $error("bmu_top serves 8-bit data only");
   end

   logic rst_meta_ff;
   logic rst_sync_ff;
   logic rst_n;
   bmu_op_e op;
   bmu_addr_t addr;
   logic [DATA_W-1:0] operand;
   logic [2*DATA_W-1:0] product;

   // reset release through two flops
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end
   assign rst_n = rst_sync_ff;

   // decode shared by operand select and product write paths
   function automatic bmu_op_e decode_op(input logic v, input logic [15:0] w);
      bmu_op_e r;
      r = BMU_OP_NONE;
      if (v && w[15:8] == `BMU_OPC_IMM_HI) begin
         r = BMU_OP_IMM;
      end else if (v && w[15:9] == `BMU_OPC_FILE_HI) begin
         r = BMU_OP_FILE;
      end
      return r;
   endfunction : decode_op

   always_comb begin
      op = decode_op(i_instr_valid, i_instr);
   end

   // operand address; access bank splits low/high at 0x80
   always_comb begin
      if (i_instr[8]) begin
         addr = {i_bank_select_register, i_instr[7:0]};
      end else if (i_instr[7:0] < `BMU_ACC_HIGH_BASE) begin
         addr = {4'h0, i_instr[7:0]};
      end else begin
         addr = {`BMU_ACC_HIGH_BANK, i_instr[7:0]};
      end
   end

   // address is combinational: memory read returns within the cycle
   assign o_mem_addr = addr;

   // operand select
   always_comb begin
      case (op)
         BMU_OP_IMM: operand = i_instr[7:0];
         BMU_OP_FILE: operand = i_mem_rdata;
         default: operand = '0;
      endcase
   end

   bmu_mult #(
      .WIDTH(DATA_W)
   ) u_mult (
      .i_a(i_acc),
      .i_b(operand),
      .o_p(product)
   );

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_product_high_byte <= `BMU_PROD_RST;
         o_product_low_byte <= `BMU_PROD_RST;
         o_prod_wr <= 1'b0;
      end else begin
         o_prod_wr <= (op != BMU_OP_NONE);
         if (op != BMU_OP_NONE) begin
            o_product_high_byte <= product[2*DATA_W-1:DATA_W];
            o_product_low_byte <= product[DATA_W-1:0];
         end
      end
   end

   // accumulator and status pass through untouched
   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_acc <= '0;
         o_status <= '0;
      end else begin
         o_acc <= i_acc;
         o_status <= i_status;
      end
   end

   // assertions share the core clock and the synchronised reset
   // immediate product value
   AST_IMM_PRODUCT: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      op == BMU_OP_IMM |=> {o_product_high_byte, o_product_low_byte} ==
      16'($past(i_acc)) * 16'($past(i_instr[7:0])))
      else $error("immediate product wrong");
   AST_FILE_PRODUCT: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      op == BMU_OP_FILE |=> {o_product_high_byte, o_product_low_byte} ==
      16'($past(i_acc)) * 16'($past(i_mem_rdata)))
      else $error("file product wrong");
   AST_HIGH_BYTE: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      op == BMU_OP_IMM |=> o_product_high_byte ==
      8'((16'($past(i_acc)) * 16'($past(i_instr[7:0]))) >> 8))
      else $error("high byte wrong");
   AST_LOW_BYTE: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      op == BMU_OP_IMM |=> o_product_low_byte ==
      8'(16'($past(i_acc)) * 16'($past(i_instr[7:0]))))
      else $error("low byte wrong");
   AST_ACC_KEPT: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      op == BMU_OP_IMM |=> o_acc == $past(i_acc))
      else $error("accumulator changed");
   AST_STATUS_KEPT: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      op != BMU_OP_NONE |=> o_status == $past(i_status))
      else $error("status changed");
   AST_FILE_ACC_KEPT: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      op == BMU_OP_FILE |=> o_acc == $past(i_acc))
      else $error("accumulator changed by file multiply");
   AST_DECODE: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      (i_instr_valid && i_instr[15:9] == 7'h01) |-> op == BMU_OP_FILE)
      else $error("file multiply not decoded");
   AST_REFUSED: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      op == BMU_OP_NONE |=> !o_prod_wr &&
      $stable(o_product_high_byte) && $stable(o_product_low_byte))
      else $error("product pair changed without multiply");
   AST_ACCESS_BANK: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      (op == BMU_OP_FILE && !i_instr[8]) |->
      o_mem_addr[11:8] == (i_instr[7] ? 4'hf : 4'h0))
      else $error("access bank address wrong");
   AST_ACCESS_OFFSET: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      (op == BMU_OP_FILE && !i_instr[8]) |->
      o_mem_addr[7:0] == i_instr[7:0])
      else $error("access bank offset wrong");
   AST_BANKED: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      (op == BMU_OP_FILE && i_instr[8]) |->
      o_mem_addr == {i_bank_select_register, i_instr[7:0]})
      else $error("banked address wrong");
   // single write strobe, unless another multiply follows
   AST_ONE_CYCLE: assert property (
      @(posedge i_clk) disable iff (!rst_n)
      op != BMU_OP_NONE |=> o_prod_wr ##1
      (!o_prod_wr || $past(op) != BMU_OP_NONE))
      else $error("product write not single cycle");
   // main scenarios worth seeing once
   COV_IMM: cover property (@(posedge i_clk) disable iff (!rst_n)
      op == BMU_OP_IMM);
   COV_FILE_BANKED: cover property (@(posedge i_clk) disable iff (!rst_n)
      op == BMU_OP_FILE && i_instr[8]);
   COV_FILE_ACCESS: cover property (@(posedge i_clk) disable iff (!rst_n)
      op == BMU_OP_FILE && !i_instr[8]);
   COV_ZERO: cover property (@(posedge i_clk) disable iff (!rst_n)
      op != BMU_OP_NONE ##1 {o_product_high_byte, o_product_low_byte} == 0);
   COV_BACK_TO_BACK: cover property (@(posedge i_clk) disable iff (!rst_n)
      op != BMU_OP_NONE ##1 op != BMU_OP_NONE);
endmodule : bmu_top

// *** tb_bmu_top.sv ***
// self-checking testbench for the byte multiply unit
`timescale 1ns/10ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
   miscompares++; $display("mismatch %s exp %h seen %h", n, e, s); end end
module tb_bmu_top;
   import bmu_pkg::*;
   logic i_clk, i_reset_n, i_instr_valid, o_prod_wr;
   logic [15:0] i_instr;
   logic [7:0] i_acc, i_status, i_mem_rdata, o_acc, o_status;
   logic [7:0] o_product_high_byte, o_product_low_byte;
   logic [3:0] i_bank_select_register;
   logic [11:0] o_mem_addr;
   logic [15:0] prod_pair;
   int miscompares = 0;
   int cmp_count = 0;
   // data memory image, same-cycle read, content derived from address
   function automatic logic [7:0] mem_of(input logic [11:0] a);
      return a[7:0] ^ {a[11:8], 4'h6};
   endfunction : mem_of
   assign i_mem_rdata = mem_of(o_mem_addr);
   assign prod_pair = {o_product_high_byte, o_product_low_byte};
   bmu_top u_bmu_top (.i_clk(i_clk), .i_reset_n(i_reset_n),
      .i_instr_valid(i_instr_valid), .i_instr(i_instr), .i_acc(i_acc),
      .i_bank_select_register(i_bank_select_register),
      .i_status(i_status), .o_mem_addr(o_mem_addr),
      .i_mem_rdata(i_mem_rdata), .o_product_high_byte(o_product_high_byte),
      .o_product_low_byte(o_product_low_byte), .o_prod_wr(o_prod_wr),
      .o_acc(o_acc), .o_status(o_status));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   // one instruction, then the cycle after and one idle cycle checked
   task automatic run_op(input logic [15:0] ins, input logic [7:0] acc,
         input logic [3:0] bank, input logic [11:0] ea, input logic [15:0] ep);
      logic [7:0] st;
      st = acc ^ 8'h5a;
      i_instr_valid = 1'b1;
      i_instr = ins;
      i_acc = acc;
      i_bank_select_register = bank;
      i_status = st;
      #1;
      if (ins[15:9] == 7'h01) `CHK("mem_addr", ea, o_mem_addr)
      @(posedge i_clk);
      #1;
      i_instr_valid = 1'b0;
      i_acc = ~acc; // later changes must not leak into held product
      i_status = ~st;
      `CHK("prod_wr", 1'b1, o_prod_wr)
      `CHK("prod_hi", ep[15:8], o_product_high_byte)
      `CHK("prod_lo", ep[7:0], o_product_low_byte)
      `CHK("acc", acc, o_acc)
      `CHK("status", st, o_status)
      @(posedge i_clk);
      #1;
      `CHK("prod_wr idle", 1'b0, o_prod_wr)
      `CHK("prod held", ep, prod_pair)
   endtask : run_op
   // immediate multiply: worked example, largest operands, zero product
   task automatic t_imm();
      run_op(16'h0dc4, 8'he2, 4'h3, 12'h000, 16'had08);
      run_op(16'h0dff, 8'hff, 4'h3, 12'h000, 16'hfe01);
      run_op(16'h0d00, 8'h9c, 4'h3, 12'h000, 16'h0000);
      $display("test imm done");
   endtask : t_imm
   // file multiply through both access bank halves and the banked mode
   task automatic file_op(input logic a, input logic [7:0] f,
         input logic [3:0] bank, input logic [7:0] acc, input logic [11:0] ea);
      run_op({7'h01, a, f}, acc, bank, ea, 16'(acc) * 16'(mem_of(ea)));
   endtask : file_op
   task automatic t_file();
      file_op(1'b0, 8'h12, 4'h5, 8'hc4, 12'h012);
      file_op(1'b0, 8'h9a, 4'h5, 8'hff, 12'hf9a);
      file_op(1'b1, 8'h9a, 4'h5, 8'h37, 12'h59a);
      file_op(1'b1, 8'h05, 4'hf, 8'h80, 12'hf05);
      $display("test file done");
   endtask : t_file
   // other opcodes and an invalid cycle leave the product pair alone
   task automatic t_refuse();
      logic [15:0] ins [3];
      ins = '{16'h0e55, 16'h0500, 16'h0dc4};
      run_op(16'h0d11, 8'h22, 4'h0, 12'h000, 16'h0242);
      foreach (ins[i]) begin
         i_instr_valid = (i < 2);
         i_instr = ins[i];
         @(posedge i_clk);
         #1;
         `CHK("prod_wr refused", 1'b0, o_prod_wr)
         `CHK("prod kept", 16'h0242, prod_pair)
      end
      $display("test refuse done");
   endtask : t_refuse
   // two multiplies in successive cycles, each lands one cycle later
   task automatic t_b2b();
      i_instr_valid = 1'b1;
      i_instr = 16'h0dc4;
      i_acc = 8'he2;
      @(posedge i_clk);
      #1;
      i_instr = {7'h01, 1'b1, 8'h9a};
      i_acc = 8'hc4;
      i_bank_select_register = 4'h5;
      `CHK("b2b first wr", 1'b1, o_prod_wr)
      `CHK("b2b first", 16'had08, prod_pair)
      @(posedge i_clk);
      #1;
      i_instr_valid = 1'b0;
      `CHK("b2b second wr", 1'b1, o_prod_wr)
      `CHK("b2b second", 16'h9c30, prod_pair)
      @(posedge i_clk);
      #1;
      `CHK("b2b idle", 1'b0, o_prod_wr)
      $display("test b2b done");
   endtask : t_b2b
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
      if (miscompares == 0 && cmp_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : end_sim
   // watchdog: tests need under 100 cycles
   initial begin
      #20000;
      miscompares++;
      end_sim();
   end
   initial begin
      i_reset_n = 1'b0;
      i_instr_valid = 1'b0;
      i_instr = 16'h0000;
      i_acc = 8'h00;
      i_status = 8'h00;
      i_bank_select_register = 4'h0;
      repeat (16) @(posedge i_clk);
      #1;
      i_reset_n = 1'b1;
      // reset synchroniser needs two edges before the first instruction
      repeat (3) @(posedge i_clk);
      #1;
      t_imm();
      t_file();
      t_refuse();
      t_b2b();
      end_sim();
   end
endmodule : tb_bmu_top
